// File: rtl/pll_cfg_pkg.sv
`default_nettype none
package pll_cfg_pkg;

    // register byte offsets on the bus
    localparam logic [11:0] OFS_FRACTION  = 12'h000; // feedback_fraction_numerator
    localparam logic [11:0] OFS_INTEGER   = 12'h004; // feedback_integer_divider
    localparam logic [11:0] OFS_MODULATOR = 12'h008; // feedback_modulator_config
    localparam logic [11:0] OFS_REFERENCE = 12'h00c; // pll_reference_config
    localparam logic [11:0] OFS_FILTER    = 12'h010; // loop_filter_config

    // field widths and the byte lane whose write applies an atomic value
    localparam int FRAC_W         = 27;  // numerator bits, denominator is 2**FRAC_W
    localparam int INT_W          = 10;  // integer divider bits
    localparam int FRAC_TOP_LANE  = 3;   // bits 31:24
    localparam int INT_TOP_LANE   = 1;   // bits 15:8

    // reset values
    localparam logic [26:0] FRAC_RST      = 27'h0000000;
    localparam logic [9:0]  INT_RST       = 10'h06c;
    localparam logic        DITHER_RST    = 1'h0;
    localparam logic        SHAPING_RST   = 1'h0;
    localparam logic [1:0]  AMPLITUDE_RST = 2'h0;
    localparam logic [1:0]  ORDER_RST     = 2'h3;
    localparam logic        REF_AUX_RST   = 1'h0;
    localparam logic        DOUBLER_RST   = 1'h1;
    localparam logic        BYPASS_RST    = 1'h0;
    localparam logic [2:0]  CAP_RST       = 3'h7;
    localparam logic [3:0]  RES_RST       = 4'h6;

    // modulator settings, packed in register bit order (bits 5:0)
    typedef struct packed {
        logic       dither_on;          // bit 5
        logic       dither_shaping_on;  // bit 4
        logic [1:0] dither_amplitude;   // bits 3:2, 1/2/4/8 lsb steps
        logic [1:0] modulator_order;    // bits 1:0, 0 = integer only
    } modulator_cfg_t;

    // reference path, register bit order (bits 1:0)
    typedef struct packed {
        logic ref_select_aux;           // 0 crystal_reference_input, 1 auxiliary_clock_input
        logic doubler_on;               // reference doubler enable
    } reference_cfg_t;

    // loop filter trims, register bit order (bits 7:0)
    typedef struct packed {
        logic       filter_bypass;        // bit 7, oscillator current-source filter bypass
        logic [2:0] pole_capacitor_code;  // bits 6:4
        logic [3:0] filter_resistor_code; // bits 3:0, 400 ohm steps
    } filter_cfg_t;

    // bus phase tracker, one-hot
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_DATA = 2'b10
    } phase_t;

endpackage
`default_nettype wire

// File: rtl/pll_feedback_config_regs.sv
// Behaviour
// - hold 27-bit numerator, denominator two to 27
// - numerator applied only on top byte write
// - hold 10-bit integer divider, reset 0x6c
// - integer applied only on upper byte write
// - dither enable bit, resets to zero
// - shaping bit shapes dither when set
// - two-bit dither gain, 1/2/4/8 lsb
// - two-bit modulator order, resets to three
// - reference select: crystal zero, auxiliary one
// - doubler enable bit, resets to one
// - oscillator filter bypass bit, resets zero
// - three-bit pole capacitor code, resets seven
// - four-bit resistor code, resets six
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pll_feedback_config_regs
(
    // clock, reset, freeze
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        clk_en,
    // ahb-lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // analog pll settings
    output logic      [26:0]                 fraction_numerator,
    output logic      [9:0]                  integer_divider,
    output pll_cfg_pkg::modulator_cfg_t      modulator_cfg,
    output pll_cfg_pkg::reference_cfg_t      reference_cfg,
    output pll_cfg_pkg::filter_cfg_t         filter_cfg
);

    // byte lanes touched by a transfer; wider than a word counts as a word
    function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] addr);
        logic [3:0] m;
        m = 4'hf;
        case (size)
            3'h0:    m = 4'h1 << addr;
            3'h1:    m = addr[1] ? 4'hc : 4'h3;
            default: m = 4'hf;
        endcase
        return m;
    endfunction

    // merge new bytes into an old word under a lane mask
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] new_w,
                                                input logic [3:0] lanes);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (lanes[i])
            begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // bus state
    pll_cfg_pkg::phase_t phase;        // idle or data phase pending
    pll_cfg_pkg::phase_t next_phase;
    logic                wr_pend;      // pending data phase is a write
    logic                next_wr_pend;
    logic [11:0]         ofs_q;        // latched offset of pending write
    logic [11:0]         next_ofs_q;
    logic [3:0]          lanes_q;      // latched lanes of pending write
    logic [3:0]          next_lanes_q;
    logic [31:0]         next_hrdata;
    logic                next_hreadyout;

    // configuration state
    logic [26:0]                  frac_shadow;      // software copy, lower bytes pending
    logic [26:0]                  next_frac_shadow;
    logic [26:0]                  next_fraction;
    logic [9:0]                   int_shadow;       // software copy of integer divider
    logic [9:0]                   next_int_shadow;
    logic [9:0]                   next_integer;
    pll_cfg_pkg::modulator_cfg_t  next_modulator;
    pll_cfg_pkg::reference_cfg_t  next_reference;
    pll_cfg_pkg::filter_cfg_t     next_filter;

    logic        take;      // address phase accepted this cycle
    logic        commit;    // write data phase completes this cycle
    logic [31:0] wmerged;   // merged write word for the pending register

    assign take   = clk_en & hsel & htrans[1] & hready & hreadyout;
    assign commit = clk_en & (phase == pll_cfg_pkg::PH_DATA) & wr_pend;

    // bus phase and read data; reads sample the shadows so pending bytes are visible
    always_comb
    begin
        next_phase     = phase;
        next_wr_pend   = wr_pend;
        next_ofs_q     = ofs_q;
        next_lanes_q   = lanes_q;
        next_hrdata    = hrdata;
        next_hreadyout = clk_en;   // stall the bus while frozen
        if (clk_en)
        begin
            next_phase   = pll_cfg_pkg::PH_IDLE;
            next_wr_pend = 1'b0;
            if (take)
            begin
                next_phase   = pll_cfg_pkg::PH_DATA;
                next_wr_pend = hwrite;
                next_ofs_q   = haddr[11:0];
                next_lanes_q = lane_mask(hsize, haddr[1:0]);
                if (!hwrite)
                begin
                    // unused and reserved bits stay zero
                    case ({haddr[11:2], 2'b00})
                        pll_cfg_pkg::OFS_FRACTION:  next_hrdata = {5'h00, frac_shadow};
                        pll_cfg_pkg::OFS_INTEGER:   next_hrdata = {22'h000000, int_shadow};
                        pll_cfg_pkg::OFS_MODULATOR: next_hrdata = {26'h0000000, modulator_cfg};
                        pll_cfg_pkg::OFS_REFERENCE: next_hrdata = {30'h00000000, reference_cfg};
                        pll_cfg_pkg::OFS_FILTER:    next_hrdata = {24'h000000, filter_cfg};
                        default:                    next_hrdata = 32'h00000000;  // unmapped
                    endcase
                end
            end
        end
    end

    // bus registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase     <= pll_cfg_pkg::PH_IDLE;
            wr_pend   <= 1'b0;
            ofs_q     <= 12'h000;
            lanes_q   <= 4'h0;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            phase     <= next_phase;
            wr_pend   <= next_wr_pend;
            ofs_q     <= next_ofs_q;
            lanes_q   <= next_lanes_q;
            hrdata    <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp     <= 1'b0;   // always okay
        end
    end

    // register writes; unaligned offsets in ofs_q low bits are lane selects, not decode
    always_comb
    begin
        next_frac_shadow = frac_shadow;
        next_fraction    = fraction_numerator;
        next_int_shadow  = int_shadow;
        next_integer     = integer_divider;
        next_modulator   = modulator_cfg;
        next_reference   = reference_cfg;
        next_filter      = filter_cfg;
        wmerged          = 32'h00000000;
        if (commit)
        begin
            case ({ofs_q[11:2], 2'b00})
                pll_cfg_pkg::OFS_FRACTION:
                begin
                    wmerged          = merge_bytes({5'h00, frac_shadow}, hwdata, lanes_q);
                    next_frac_shadow = wmerged[26:0];          // bits 31:27 dropped
                    if (lanes_q[pll_cfg_pkg::FRAC_TOP_LANE])
                    begin
                        next_fraction = wmerged[26:0];        // atomic apply
                    end
                end
                pll_cfg_pkg::OFS_INTEGER:
                begin
                    wmerged         = merge_bytes({22'h000000, int_shadow}, hwdata, lanes_q);
                    next_int_shadow = wmerged[9:0];
                    if (lanes_q[pll_cfg_pkg::INT_TOP_LANE])
                    begin
                        next_integer = wmerged[9:0];          // atomic apply
                    end
                end
                pll_cfg_pkg::OFS_MODULATOR:
                begin
                    if (lanes_q[0])
                    begin
                        next_modulator = hwdata[5:0];
                    end
                end
                pll_cfg_pkg::OFS_REFERENCE:
                begin
                    if (lanes_q[0])
                    begin
                        next_reference = hwdata[1:0];
                    end
                end
                pll_cfg_pkg::OFS_FILTER:
                begin
                    if (lanes_q[0])
                    begin
                        next_filter = hwdata[7:0];
                    end
                end
                default:
                begin
                    wmerged = 32'h00000000;                   // unmapped write ignored
                end
            endcase
        end
    end

    // configuration registers; all but the two shadows feed analog trims directly
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frac_shadow        <= pll_cfg_pkg::FRAC_RST;
            fraction_numerator <= pll_cfg_pkg::FRAC_RST;
            int_shadow         <= pll_cfg_pkg::INT_RST;
            integer_divider    <= pll_cfg_pkg::INT_RST;
            modulator_cfg      <= {pll_cfg_pkg::DITHER_RST, pll_cfg_pkg::SHAPING_RST,
                                   pll_cfg_pkg::AMPLITUDE_RST, pll_cfg_pkg::ORDER_RST};
            reference_cfg      <= {pll_cfg_pkg::REF_AUX_RST, pll_cfg_pkg::DOUBLER_RST};
            filter_cfg         <= {pll_cfg_pkg::BYPASS_RST, pll_cfg_pkg::CAP_RST,
                                   pll_cfg_pkg::RES_RST};
        end
        else
        begin
            frac_shadow        <= next_frac_shadow;
            fraction_numerator <= next_fraction;
            int_shadow         <= next_int_shadow;
            integer_divider    <= next_integer;
            modulator_cfg      <= next_modulator;
            reference_cfg      <= next_reference;
            filter_cfg         <= next_filter;
        end
    end

    // checks, all in the hclk domain
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic wr_frac;  // write commit to the fraction register
    logic wr_int;   // write commit to the integer register
    assign wr_frac = commit && ({ofs_q[11:2], 2'b00} == pll_cfg_pkg::OFS_FRACTION);
    assign wr_int  = commit && ({ofs_q[11:2], 2'b00} == pll_cfg_pkg::OFS_INTEGER);

    a_frac_full_apply: assert property (wr_frac && lanes_q == 4'hf
        |=> fraction_numerator == $past(hwdata[26:0]))
        else $error("full word write did not apply numerator");
    a_frac_low_hold: assert property (wr_frac && !lanes_q[3] |=> $stable(fraction_numerator))
        else $error("numerator changed on lower byte write");
    a_frac_shadow_move: assert property (wr_frac && lanes_q == 4'h8
        |=> fraction_numerator[23:0] == $past(frac_shadow[23:0]))
        else $error("shadow bytes not applied with top byte");
    a_int_low_hold: assert property (wr_int && !lanes_q[1] |=> $stable(integer_divider))
        else $error("integer divider changed on lower byte write");
    a_int_top_apply: assert property (wr_int && lanes_q == 4'h2
        |=> integer_divider == {$past(hwdata[9:8]), $past(int_shadow[7:0])})
        else $error("integer divider not applied on upper byte");
    // a whole word carries the top lane, so it applies at once
    a_int_full_apply: assert property (wr_int && lanes_q == 4'hf
        |=> integer_divider == $past(hwdata[9:0]))
        else $error("word write did not apply integer divider");
    // hrdata is loaded from the value standing at the address edge, not the one after it
    a_reserved_zero: assert property (take && !hwrite && haddr[11:0] == pll_cfg_pkg::OFS_MODULATOR
        |=> hrdata[31:6] == 26'h0000000 && hrdata[5:0] == $past(modulator_cfg))
        else $error("modulator readback wrong or reserved bits set");
    a_frac_read_top: assert property (take && !hwrite && haddr[11:0] == pll_cfg_pkg::OFS_FRACTION
        |=> hrdata[31:27] == 5'h00)
        else $error("numerator reserved bits read nonzero");
    a_modulator_write: assert property (commit && lanes_q[0]
        && {ofs_q[11:2], 2'b00} == pll_cfg_pkg::OFS_MODULATOR |=> modulator_cfg == $past(hwdata[5:0]))
        else $error("modulator settings not written");
    a_reference_write: assert property (commit && lanes_q[0]
        && {ofs_q[11:2], 2'b00} == pll_cfg_pkg::OFS_REFERENCE |=> reference_cfg == $past(hwdata[1:0]))
        else $error("reference settings not written");
    a_filter_write: assert property (commit && lanes_q[0]
        && {ofs_q[11:2], 2'b00} == pll_cfg_pkg::OFS_FILTER |=> filter_cfg == $past(hwdata[7:0]))
        else $error("filter settings not written");
    a_freeze_hold: assert property (!clk_en
        |=> $stable(filter_cfg) && $stable(integer_divider) && !hreadyout)
        else $error("state moved while frozen");
    a_okay_only: assert property (hresp == 1'b0)
        else $error("error response driven");

    c_frac_split: cover property (wr_frac && !lanes_q[3] ##[1:40] wr_frac && lanes_q[3]);
    c_int_apply: cover property (wr_int && lanes_q[1]);
    c_filter_read: cover property (take && !hwrite && haddr[11:0] == pll_cfg_pkg::OFS_FILTER);
    c_freeze: cover property (!clk_en [*3] ##1 clk_en);

endmodule
`default_nettype wire

// File: test/pll_feedback_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pll_feedback_config_regs_tb;

    // clock, reset and bus drive, all set by the bench
    logic                           hclk;
    logic                           hresetn;
    logic                           clk_en;
    logic                           hsel;
    logic [31:0]                    haddr;
    logic [1:0]                     htrans;
    logic                           hwrite;
    logic [2:0]                     hsize;
    logic [31:0]                    hwdata;
    // slave answers and analog settings
    logic [31:0]                    hrdata;
    logic                           hreadyout;
    logic                           hresp;
    logic                           hready;
    logic [26:0]                    fraction_numerator;
    logic [9:0]                     integer_divider;
    pll_cfg_pkg::modulator_cfg_t    modulator_cfg;
    pll_cfg_pkg::reference_cfg_t    reference_cfg;
    pll_cfg_pkg::filter_cfg_t       filter_cfg;
    // bench bookkeeping
    int                             n_mismatch;
    int                             checked;
    logic                           ready_seen;
    logic [31:0]                    rdata_seen;
    logic [31:0]                    rv;

    // single slave, so its hreadyout is the bus hready
    assign hready = hreadyout;

    pll_feedback_config_regs dut_u
    (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fraction_numerator(fraction_numerator), .integer_divider(integer_divider),
        .modulator_cfg(modulator_cfg), .reference_cfg(reference_cfg), .filter_cfg(filter_cfg)
    );

    // 200 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // sample slave outputs mid-cycle, so the rising edge never races the registers
    always @(negedge hclk)
    begin
        ready_seen = hreadyout;
        rdata_seen = hrdata;
    end

    // one compare for every value checked
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (ready_seen !== 1'b1 && n < 100);
        // a hung bus ends the run through the same verdict
        if (n >= 100)
        begin
            chk("hready wait", 32'h1, 32'h0);
            test_done();
        end
    endtask

    // one transfer: address phase, then data phase; leaves an idle cycle before it
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [2:0] sz,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= sz;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = rdata_seen;
        // let this edge's register updates land before anyone looks
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [2:0] sz, input logic [31:0] d);
        xfer(1'b1, a, sz, d, rv);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 3'h2, 32'h00000000, rv);
        chk(what, exp, rv);
    endtask

    // all reset values at the trims, and on readback for every register but the fraction
    task automatic t_reset();
        chk("fraction", 32'h00000000, {5'h00, fraction_numerator});
        chk("integer", 32'h0000006c, {22'h000000, integer_divider});
        chk("modulator", 32'h00000003, {26'h0000000, modulator_cfg});
        chk("reference", 32'h00000001, {30'h00000000, reference_cfg});
        chk("filter", 32'h00000076, {24'h000000, filter_cfg});
        rd_chk("rd integer", pll_cfg_pkg::OFS_INTEGER, 32'h0000006c);
        rd_chk("rd modulator", pll_cfg_pkg::OFS_MODULATOR, 32'h00000003);
        rd_chk("rd reference", pll_cfg_pkg::OFS_REFERENCE, 32'h00000001);
        rd_chk("rd filter", pll_cfg_pkg::OFS_FILTER, 32'h00000076);
        $display("test reset done");
    endtask

    // low bytes wait in the shadow; the top byte applies the merged value
    task automatic t_fraction();
        wr(12'h000, 3'h0, 32'h111111ab);
        wr(12'h001, 3'h0, 32'h2222cd22);
        wr(12'h002, 3'h0, 32'h33ef3333);
        chk("fraction held", 32'h00000000, {5'h00, fraction_numerator});
        rd_chk("rd fraction shadow", 12'h000, 32'h00efcdab);
        // reserved bits 31:27 of the top byte must be dropped
        wr(12'h003, 3'h0, 32'hfe444444);
        chk("fraction applied", 32'h06efcdab, {5'h00, fraction_numerator});
        rd_chk("rd fraction", 12'h000, 32'h06efcdab);
        wr(12'h000, 3'h2, 32'hffffffff);
        chk("fraction full", 32'h07ffffff, {5'h00, fraction_numerator});
        $display("test fraction done");
    endtask

    // integer divider: low byte shadowed, upper byte applies
    task automatic t_integer();
        wr(12'h004, 3'h0, 32'h00000055);
        chk("integer held", 32'h0000006c, {22'h000000, integer_divider});
        wr(12'h005, 3'h0, 32'h0000ff00);
        chk("integer applied", 32'h00000355, {22'h000000, integer_divider});
        rd_chk("rd integer", 12'h004, 32'h00000355);
        wr(12'h004, 3'h2, 32'hffff0000);
        chk("integer word", 32'h00000000, {22'h000000, integer_divider});
        $display("test integer done");
    endtask

    // every code of every field, reserved bits written as ones
    task automatic t_fields();
        logic [7:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v = {2'b00, i[0], ~i[0], i[1:0], 2'(3 - i)};
            wr(pll_cfg_pkg::OFS_MODULATOR, 3'h2, {24'hffffff, 2'b11, v[5:0]});
            chk("modulator", {24'h0, v}, {26'h0000000, modulator_cfg});
            rd_chk("rd modulator", pll_cfg_pkg::OFS_MODULATOR, {24'h0, v});
            wr(pll_cfg_pkg::OFS_REFERENCE, 3'h2, {30'h3fffffff, i[1:0]});
            chk("reference", {30'h0, i[1:0]}, {30'h00000000, reference_cfg});
            rd_chk("rd reference", pll_cfg_pkg::OFS_REFERENCE, {30'h0, i[1:0]});
        end
        for (int i = 0; i < 16; i++)
        begin
            v = {i[0], 3'(i), 4'(15 - i)};
            wr(pll_cfg_pkg::OFS_FILTER, 3'h2, {24'hffffff, v});
            chk("filter", {24'h0, v}, {24'h000000, filter_cfg});
            rd_chk("rd filter", pll_cfg_pkg::OFS_FILTER, {24'h0, v});
        end
        $display("test fields done");
    endtask

    // a write to an unmapped place changes nothing and reads zero
    task automatic t_unmapped();
        wr(12'h014, 3'h2, 32'hffffffff);
        rd_chk("rd unmapped", 12'h014, 32'h00000000);
        rd_chk("rd filter kept", pll_cfg_pkg::OFS_FILTER, 32'h000000f0);
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("test unmapped done");
    endtask

    // clock enable low stalls the bus and holds the trims; the pending write lands once it returns
    task automatic t_freeze();
        @(posedge hclk);
        clk_en <= 1'b0;
        fork
            wr(pll_cfg_pkg::OFS_FILTER, 3'h2, 32'h00000012);
            begin
                repeat (3) @(posedge hclk);
                chk("frozen ready", 32'h0, {31'h0, ready_seen});
                chk("frozen filter", 32'h000000f0, {24'h000000, filter_cfg});
                @(posedge hclk);
                clk_en <= 1'b1;
            end
        join
        chk("filter after freeze", 32'h00000012, {24'h000000, filter_cfg});
        rd_chk("rd filter after freeze", pll_cfg_pkg::OFS_FILTER, 32'h00000012);
        $display("test freeze done");
    endtask

    // verdict and end of run, from the tests or the watchdog
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial
    begin
        n_mismatch = 0;
        checked    = 0;
        hresetn    = 1'b0;
        clk_en     = 1'b1;
        hsel       = 1'b0;
        haddr      = 32'h00000000;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h00000000;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        t_reset();
        t_fraction();
        t_integer();
        t_fields();
        t_unmapped();
        t_freeze();
        test_done();
    end

    // watchdog: the tests take well under 2000 cycles
    initial
    begin
        #100000;
        n_mismatch++;
        test_done();
    end

endmodule
`default_nettype wire
